// ---- hrpmc_pkg.sv ----
// Constants, types and register map for the high rate PHY mode controller.
package hrpmc_pkg;
   // Timing base.
   localparam int CLK_MHZ = 100;
   localparam int SYMBOL_US = 16;
   localparam int ED_STD_SYMBOLS = 8;
   localparam int ED_HR_US = 32;
   localparam int ACK_LONG_SYMBOLS = 12;
   localparam int ACK_SHORT_SYMBOLS = 2;
   localparam int ED_STD_CYCLES = ED_STD_SYMBOLS * SYMBOL_US * CLK_MHZ;
   localparam int ED_HR_CYCLES = ED_HR_US * CLK_MHZ;
   localparam int ACK_LONG_CYCLES = ACK_LONG_SYMBOLS * SYMBOL_US * CLK_MHZ;
   localparam int ACK_SHORT_CYCLES = ACK_SHORT_SYMBOLS * SYMBOL_US * CLK_MHZ;
   localparam int CNT_W = 16;

   // Register addresses.
   localparam logic [5:0] ADDR_TRANSCEIVER_CONTROL_TWO = 6'h0C;
   localparam logic [5:0] ADDR_RECEIVE_SYNC_THRESHOLD = 6'h15;
   localparam logic [5:0] ADDR_EXTENDED_CONTROL = 6'h17;

   // Field positions, reset values and writable masks.
   localparam int TC2_SCRAM_BIT = 5;
   localparam int XC_ACK_TIME_BIT = 2;
   localparam logic [7:0] TC2_RESET = 8'h20;
   localparam logic [7:0] RSYN_RESET = 8'h00;
   localparam logic [7:0] XC_RESET = 8'h00;
   localparam logic [7:0] TC2_WMASK = 8'hA7;
   localparam logic [7:0] RSYN_WMASK = 8'h0F;
   localparam logic [7:0] XC_WMASK = 8'hF7;

   // Payload rate codes.
   localparam logic [2:0] RATE_250 = 3'h0;
   localparam logic [2:0] RATE_500 = 3'h1;
   localparam logic [2:0] RATE_1000 = 3'h2;
   localparam logic [2:0] RATE_2000 = 3'h3;

   // Command byte prefixes.
   localparam logic [2:0] CMD_FB_READ = 3'h1;
   localparam logic [1:0] CMD_REG_READ = 2'h2;
   localparam logic [1:0] CMD_REG_WRITE = 2'h3;

   // Frame store and acknowledgment frame.
   localparam int FB_DEPTH = 128;
   localparam int FB_AW = 7;
   localparam logic [6:0] ACK_PSDU_LEN = 7'h05;

   typedef enum logic [2:0] {
      SPI_IDLE = 3'h0,
      SPI_CMD = 3'h1,
      SPI_FRAME = 3'h3,
      SPI_REG_RD = 3'h2,
      SPI_REG_WR = 3'h6,
      SPI_DONE = 3'h7
   } hrpmc_spi_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_HDR = 2'h1,
      RX_PAY = 2'h3,
      RX_DROP = 2'h2
   } hrpmc_rx_t;

   // Payload sensitivity in 3 dB steps above the signal floor, per payload rate.
   function automatic logic [3:0] pay_sens(input logic [2:0] rate);
      case (rate)
         RATE_500: pay_sens = 4'h1;
         RATE_1000: pay_sens = 4'h2;
         RATE_2000: pay_sens = 4'h4;
         default: pay_sens = 4'h0;
      endcase
   endfunction : pay_sens
endpackage : hrpmc_pkg

// ---- hrpmc_frame_store.sv ----
// Frame store: payload byte memory with one write port and one registered read port.
`timescale 1ns/1ps
module hrpmc_frame_store
   import hrpmc_pkg::*;
#(
   parameter int DEPTH = FB_DEPTH,
   parameter int AW = FB_AW,
   parameter int DW = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic en,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [DEPTH];

   // The array has no reset; only bytes beyond the received length can be stale.
   always_ff @(posedge clock) begin
      if (en && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read data is registered so the SPI side sees it one clock after the address.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rd_data <= '0;
      end else if (en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : hrpmc_frame_store

// ---- hrpmc_ctrl.sv ----
// High rate PHY mode controller: registers over SPI, frame read-out, ED and ACK timing.
`timescale 1ns/1ps
// How it works
// RULE1: Sync and PHY headers always run at the base rate; the selected rate covers only payload.
// RULE2: In a frame read the byte right after the payload is the link quality byte, invalid at high rate.
// RULE3: A command with prefix 001 returns state byte, length, payload, link quality, ED value, then status.
// RULE4: Above the base rate the automatic ED measurement lasts 32 us instead of eight symbols.
// RULE5: With a nonzero threshold, frames weaker than the threshold are ignored.
// RULE6: With threshold zero, a high rate frame whose payload is below payload sensitivity is dropped.
// RULE7: The host should set the threshold to at least 1 at the top rate.
// RULE8: At the top rate chip scrambling is on while the scrambler enable bit is one.
// RULE9: In high rate modes clear channel assessment is energy above threshold only.
// RULE10: In high rate modes the host discards the link quality byte.
// RULE11: In auto-ack receive the ACK starts 32 us after frame end with short turnaround, else 192 us.
// RULE12: The ACK frame carries a payload length of five octets.
// RULE13: Rate field bits 2:0 select 250, 500, 1000 or 2000 kb/s, reset 0, other codes reserved.
// RULE14: Threshold field bits 3:0 lower sensitivity in 3 dB steps, 0 being most sensitive.
// RULE15: Both hosts must agree on a non-default rate in advance, since frames do not signal it.
// RULE16: Short turnaround is bit 2 of the register at 0x17: 0 means 12 symbols, 1 two symbols.
// RULE17: The host changes the rate only while no frame is in flight.
module hrpmc_ctrl
   import hrpmc_pkg::*;
#(
   parameter int ED_STD_CYC = ED_STD_CYCLES,
   parameter int ACK_LONG_CYC = ACK_LONG_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic en,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_sel_n,
   output logic spi_miso,
   input wire logic rx_sync_found,
   input wire logic [3:0] rx_rssi,
   input wire logic rx_phr_valid,
   input wire logic [7:0] rx_phr,
   input wire logic rx_data_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_frame_end,
   input wire logic rx_crc_ok,
   input wire logic [7:0] rx_lqi,
   input wire logic rx_ack_request,
   input wire logic auto_ack_receive_state,
   input wire logic tx_payload_active,
   input wire logic ed_start,
   input wire logic [7:0] ed_level,
   output logic [2:0] modem_rate,
   output logic chip_scramble,
   output logic cca_energy_only,
   output logic ed_busy,
   output logic ed_done,
   output logic [7:0] ed_value,
   output logic frame_ready,
   output logic frame_dropped,
   output logic ack_tx_start,
   output logic [6:0] ack_psdu_length
);
   typedef struct packed {
      logic [7:0] tc2;
      logic [7:0] rsyn;
      logic [7:0] xc;
      hrpmc_spi_t spi;
      logic sclk_p;
      logic [2:0] bitcnt;
      logic [7:0] sh_in;
      logic [7:0] sh_out;
      logic miso;
      logic [5:0] addr;
      logic [7:0] idx;
      logic [6:0] rd_addr;
      hrpmc_rx_t rx;
      logic [6:0] len;
      logic [6:0] wcnt;
      logic wr_en;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic stored;
      logic dropped;
      logic [7:0] lqi;
      logic [7:0] rstat;
      logic [7:0] edv;
      logic [CNT_W-1:0] ed_cnt;
      logic ed_busy;
      logic ed_done;
      logic [CNT_W-1:0] ack_cnt;
      logic ack_wait;
      logic ack_start;
      logic [6:0] ack_len;
      logic tx_act;
      logic [2:0] rate;
      logic scram;
      logic cca_ed;
   } hrpmc_state_t;

   hrpmc_state_t s_q;
   hrpmc_state_t s_d;
   logic [7:0] rd_data;
   logic hr;
   logic rise;
   logic fall;
   logic [7:0] b;
   logic [7:0] phy_state;
   logic [3:0] thr;

   // Shared decodes of the current state and the sampled SPI pins.
   assign hr = (s_q.tc2[2:0] != RATE_250);
   assign rise = spi_sclk & ~s_q.sclk_p;
   assign fall = ~spi_sclk & s_q.sclk_p;
   assign b = {s_q.sh_in[6:0], spi_mosi};
   assign thr = s_q.rsyn[3:0];
   assign phy_state = {s_q.stored, s_q.ed_busy, s_q.ack_wait, s_q.rx != RX_IDLE, 1'b0,
                       s_q.tc2[2:0]};

   hrpmc_frame_store u_store (
      .clock(clock),
      .resetn(resetn),
      .en(en),
      .wr_en(s_q.wr_en),
      .wr_addr(s_q.wr_addr),
      .wr_data(s_q.wr_data),
      .rd_addr(s_q.rd_addr),
      .rd_data(rd_data)
   );

   // Next-state logic for the SPI slave, receive control, ED timer and ACK timer.
   always_comb begin
      logic [7:0] fb;
      logic [7:0] rr;
      logic [7:0] nb;
      fb = 8'h00;
      rr = 8'h00;
      nb = 8'h00;
      s_d = s_q;
      s_d.wr_en = 1'b0;
      s_d.dropped = 1'b0;
      s_d.ed_done = 1'b0;
      s_d.ack_start = 1'b0;
      s_d.sclk_p = spi_sclk;
      // Frame read byte for the current index.
      if (s_q.idx == 8'h00) begin
         fb = {1'b0, s_q.len}; // see RULE3
      end else if (s_q.idx <= {1'b0, s_q.len}) begin
         fb = rd_data;
      end else if (s_q.idx == {1'b0, s_q.len} + 8'h01) begin
         fb = s_q.lqi; // see RULE2
      end else if (s_q.idx == {1'b0, s_q.len} + 8'h02) begin
         fb = s_q.edv; // see RULE3
      end else if (s_q.idx == {1'b0, s_q.len} + 8'h03) begin
         fb = s_q.rstat;
      end
      // Register read decode; unmapped addresses read zero.
      case (s_q.addr)
         ADDR_TRANSCEIVER_CONTROL_TWO: rr = s_q.tc2;
         ADDR_RECEIVE_SYNC_THRESHOLD: rr = s_q.rsyn;
         ADDR_EXTENDED_CONTROL: rr = s_q.xc;
         default: rr = 8'h00;
      endcase
      // SPI mode 0: sample on the rising edge, shift out on the falling edge.
      if (spi_sel_n) begin
         s_d.spi = SPI_IDLE;
         s_d.bitcnt = 3'h0;
         s_d.miso = 1'b0;
      end else if (s_q.spi == SPI_IDLE) begin
         s_d.spi = SPI_CMD;
         s_d.sh_out = phy_state; // see RULE3
         s_d.miso = phy_state[7];
      end else if (rise) begin
         s_d.sh_in = b;
         s_d.bitcnt = s_q.bitcnt + 3'h1;
         if (s_q.bitcnt == 3'h7) begin
            unique case (s_q.spi)
               SPI_CMD: begin
                  s_d.addr = b[5:0];
                  s_d.idx = 8'h00;
                  s_d.rd_addr = 7'h00;
                  if (b[7:5] == CMD_FB_READ) begin
                     s_d.spi = SPI_FRAME; // see RULE3
                  end else if (b[7:6] == CMD_REG_READ) begin
                     s_d.spi = SPI_REG_RD;
                  end else if (b[7:6] == CMD_REG_WRITE) begin
                     s_d.spi = SPI_REG_WR;
                  end else begin
                     s_d.spi = SPI_DONE;
                  end
               end
               SPI_REG_WR: begin
                  if (s_q.addr == ADDR_TRANSCEIVER_CONTROL_TWO) begin
                     s_d.tc2 = b & TC2_WMASK;
                     // A reserved rate code is refused and the old rate kept.
                     if (b[2:0] > RATE_2000) begin
                        s_d.tc2[2:0] = s_q.tc2[2:0]; // see RULE13
                     end
                  end
                  if (s_q.addr == ADDR_RECEIVE_SYNC_THRESHOLD) begin
                     s_d.rsyn = b & RSYN_WMASK; // see RULE14
                  end
                  if (s_q.addr == ADDR_EXTENDED_CONTROL) begin
                     s_d.xc = b & XC_WMASK; // see RULE16
                  end
                  s_d.spi = SPI_DONE;
               end
               SPI_REG_RD: s_d.spi = SPI_DONE;
               SPI_FRAME: s_d.spi = SPI_FRAME;
               SPI_DONE: s_d.spi = SPI_DONE;
               SPI_IDLE: s_d.spi = SPI_IDLE;
               default: s_d.spi = SPI_DONE;
            endcase
         end
      end else if (fall) begin
         if (s_q.bitcnt == 3'h0) begin
            if (s_q.spi == SPI_REG_RD) begin
               nb = rr;
            end else if (s_q.spi == SPI_FRAME) begin
               nb = fb;
               // The store reads one byte ahead so data is ready at the next boundary.
               s_d.rd_addr = s_q.idx[6:0];
               if (s_q.idx != 8'hFF) begin
                  s_d.idx = s_q.idx + 8'h01;
               end
            end
            s_d.sh_out = nb;
            s_d.miso = nb[7];
         end else begin
            s_d.sh_out = {s_q.sh_out[6:0], 1'b0};
            s_d.miso = s_q.sh_out[6];
         end
      end
      // Receive control: header at base rate, then payload into the store.
      unique case (s_q.rx)
         RX_IDLE: begin
            if (rx_sync_found) begin
               if (thr != 4'h0 && rx_rssi < thr) begin
                  s_d.rx = RX_DROP; // see RULE5
               end else begin
                  s_d.rx = RX_HDR; // see RULE1
               end
            end
         end
         RX_HDR: begin
            if (rx_frame_end) begin
               s_d.rx = RX_IDLE;
            end else if (rx_phr_valid) begin
               s_d.len = rx_phr[6:0];
               s_d.wcnt = 7'h00;
               s_d.stored = 1'b0;
               s_d.rx = RX_PAY;
            end
         end
         RX_PAY: begin
            if (rx_data_valid && s_q.wcnt < s_q.len) begin
               s_d.wr_en = 1'b1;
               s_d.wr_addr = s_q.wcnt;
               s_d.wr_data = rx_data;
               s_d.wcnt = s_q.wcnt + 7'h01;
            end
            if (rx_frame_end) begin
               s_d.rx = RX_IDLE;
               if (thr == 4'h0 && hr && rx_rssi < pay_sens(s_q.tc2[2:0])) begin
                  s_d.dropped = 1'b1; // see RULE6
               end else begin
                  s_d.stored = 1'b1;
                  s_d.lqi = rx_lqi;
                  s_d.rstat = {rx_crc_ok, hr, 6'h00}; // see RULE2
                  if (auto_ack_receive_state && rx_ack_request) begin
                     s_d.ack_wait = 1'b1;
                     s_d.ack_cnt = s_q.xc[XC_ACK_TIME_BIT] ? CNT_W'(ACK_SHORT_CYCLES - 1)
                                                          : CNT_W'(ACK_LONG_CYC - 1); // see RULE11
                  end
               end
            end
         end
         RX_DROP: begin
            if (rx_frame_end) begin
               s_d.rx = RX_IDLE;
               s_d.dropped = 1'b1;
            end
         end
      endcase
      // Energy detection window, shortened at high rates.
      if (s_q.ed_busy) begin
         if (s_q.ed_cnt == '0) begin
            s_d.ed_busy = 1'b0;
            s_d.ed_done = 1'b1;
            s_d.edv = ed_level;
         end else begin
            s_d.ed_cnt = s_q.ed_cnt - 1'b1;
         end
      end else if (ed_start) begin
         s_d.ed_busy = 1'b1;
         s_d.ed_cnt = hr ? CNT_W'(ED_HR_CYCLES - 1) : CNT_W'(ED_STD_CYC - 1); // see RULE4
      end
      // Acknowledgment turnaround countdown.
      if (s_q.ack_wait) begin
         if (s_q.ack_cnt == '0) begin
            s_d.ack_wait = 1'b0;
            s_d.ack_start = 1'b1;
         end else begin
            s_d.ack_cnt = s_q.ack_cnt - 1'b1;
         end
      end
      // Modem steering outputs; the rate drops to base outside payload.
      s_d.tx_act = tx_payload_active;
      s_d.rate = (s_q.rx == RX_PAY || s_q.tx_act) ? s_q.tc2[2:0] : RATE_250; // see RULE1
      s_d.scram = (s_d.rate == RATE_2000) && s_q.tc2[TC2_SCRAM_BIT]; // see RULE8
      s_d.cca_ed = hr; // see RULE9
      s_d.ack_len = ACK_PSDU_LEN; // see RULE12
   end

   // All control state except the frame store and helper counters is held here; a low clock enable freezes it.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.tc2 <= TC2_RESET;
         s_q.rsyn <= RSYN_RESET;
         s_q.xc <= XC_RESET;
         s_q.ack_len <= ACK_PSDU_LEN;
      end else if (en) begin
         s_q <= s_d;
      end
   end

   assign spi_miso = s_q.miso;
   assign modem_rate = s_q.rate;
   assign chip_scramble = s_q.scram;
   assign cca_energy_only = s_q.cca_ed;
   assign ed_busy = s_q.ed_busy;
   assign ed_done = s_q.ed_done;
   assign ed_value = s_q.edv;
   assign frame_ready = s_q.stored;
   assign frame_dropped = s_q.dropped;
   assign ack_tx_start = s_q.ack_start;
   assign ack_psdu_length = s_q.ack_len;

   // Helper counters that measure the ED window and ACK gap independently.
   logic [CNT_W-1:0] ed_run_h;
   logic [CNT_W-1:0] ed_need_h;
   logic [CNT_W-1:0] ack_run_h;
   logic [CNT_W-1:0] ack_need_h;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ed_run_h <= '0;
         ed_need_h <= '0;
         ack_run_h <= '0;
         ack_need_h <= '0;
      end else if (en) begin
         ed_run_h <= s_q.ed_busy ? ed_run_h + 1'b1 : '0;
         ack_run_h <= s_q.ack_wait ? ack_run_h + 1'b1 : '0;
         if (!s_q.ed_busy) begin
            ed_need_h <= hr ? CNT_W'(32 * CLK_MHZ) : CNT_W'(ED_STD_CYC);
         end
         if (!s_q.ack_wait) begin
            ack_need_h <= s_q.xc[2] ? CNT_W'(32 * CLK_MHZ) : CNT_W'(ACK_LONG_CYC);
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn || !en);

   AST_HDR_BASE_RATE: assert property ((s_q.rx == RX_HDR && !s_q.tx_act) |=> s_q.rate == 3'h0) // see RULE1
      else $error("Header not sent at base rate.");
   AST_LQI_SLOT: assert property ((!spi_sel_n && fall && s_q.spi == SPI_FRAME && s_q.bitcnt == 3'h0
      && s_q.idx == {1'b0, s_q.len} + 8'h01) |=> s_q.sh_out == $past(s_q.lqi)) // see RULE2
      else $error("Byte after payload is not link quality.");
   AST_FB_PREFIX: assert property ((!spi_sel_n && rise && s_q.spi == SPI_CMD && s_q.bitcnt == 3'h7
      && b[7:5] == 3'h1) |=> s_q.spi == SPI_FRAME ##0 s_q.idx == 8'h00) // see RULE3
      else $error("Frame read command not decoded.");
   AST_ED_WINDOW: assert property ($fell(s_q.ed_busy) |-> ed_run_h == ed_need_h) // see RULE4
      else $error("ED window length wrong.");
   AST_THR_DROP: assert property ((s_q.rx == RX_IDLE && rx_sync_found && thr != 4'h0
      && rx_rssi < thr) |=> s_q.rx == RX_DROP) // see RULE5
      else $error("Weak frame not ignored.");
   AST_WEAK_PAYLOAD: assert property ((s_q.rx == RX_PAY && rx_frame_end && thr == 4'h0 && hr
      && rx_rssi < pay_sens(s_q.tc2[2:0])) |=> s_q.dropped && !s_q.stored) // see RULE6
      else $error("Weak high rate payload delivered.");
   AST_SCRAMBLE: assert property (s_q.scram |-> s_q.rate == 3'h3 && $past(s_q.tc2[5])) // see RULE8
      else $error("Scrambling outside top rate.");
   AST_CCA_ENERGY: assert property (s_q.cca_ed == $past(hr)) // see RULE9
      else $error("Carrier sense allowed at high rate.");
   AST_ACK_GAP: assert property ($fell(s_q.ack_wait) |-> ack_run_h == ack_need_h
      ##0 s_q.ack_start) // see RULE11
      else $error("ACK turnaround length wrong.");
   AST_ACK_LEN: assert property (s_q.ack_start |-> s_q.ack_len == 7'h05) // see RULE12
      else $error("ACK length not five.");
   AST_RATE_LEGAL: assert property (s_q.tc2[2:0] <= 3'h3 && s_q.tc2[6] == 1'b0) // see RULE13
      else $error("Reserved rate code held.");
   AST_THR_FIELD: assert property (s_q.rsyn[7:4] == 4'h0) // see RULE14
      else $error("Threshold register upper bits set.");

   COV_FB_READ: cover property (s_q.spi == SPI_FRAME && s_q.idx > {1'b0, s_q.len} + 8'h02);
   COV_HR_DROP: cover property (s_q.dropped && hr);
   COV_SHORT_ACK: cover property (s_q.ack_start && s_q.xc[2]);
   COV_ED_HR: cover property (s_q.ed_done && hr);
endmodule : hrpmc_ctrl

// ---- hrpmc_spi_host.sv ----
// Host side SPI model that shifts bytes into and out of the controller.
`timescale 1ns/1ps
module hrpmc_spi_host (
   input wire logic clock,
   input wire logic spi_miso,
   output logic spi_sclk,
   output logic spi_mosi,
   output logic spi_sel_n
);
   logic [7:0] tx_buf [0:15];
   logic [7:0] rx_buf [0:15];

   // Idle bus: select high, clock low in mode 0.
   initial begin
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
      spi_sel_n = 1'b1;
      foreach (tx_buf[i]) tx_buf[i] = 8'h00;
   end

   // MOSI is set while SCLK is low and MISO is taken as SCLK rises, MSB first.
   // Each SCLK phase lasts 4 clocks so the controller sees every edge.
   task automatic xfer(input int n);
      @(posedge clock);
      spi_sel_n <= 1'b0;
      repeat (4) @(posedge clock);
      for (int b = 0; b < n; b++) begin
         for (int i = 7; i >= 0; i--) begin
            spi_mosi <= tx_buf[b][i];
            repeat (4) @(posedge clock);
            spi_sclk <= 1'b1;
            rx_buf[b][i] = spi_miso;
            repeat (4) @(posedge clock);
            spi_sclk <= 1'b0;
         end
      end
      repeat (4) @(posedge clock);
      spi_sel_n <= 1'b1;
      // A released MOSI shows the inverse of its last bit, not a stale copy.
      spi_mosi <= ~spi_mosi;
      repeat (3) @(posedge clock);
   endtask : xfer
endmodule : hrpmc_spi_host

// ---- tb_top.sv ----
// Self-checking bench for the high rate PHY mode controller.
`timescale 1ns/1ps
module tb_top;
   import hrpmc_pkg::*;
   localparam int ED_N = 40;
   localparam int ACK_N = 60;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic en = 1'b1;
   logic spi_sclk, spi_mosi, spi_sel_n, spi_miso;
   logic rx_sync_found = 1'b0;
   logic [3:0] rx_rssi = 4'hF;
   logic rx_phr_valid = 1'b0;
   logic [7:0] rx_phr = 8'h00;
   logic rx_data_valid = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic rx_frame_end = 1'b0;
   logic rx_crc_ok = 1'b1;
   logic [7:0] rx_lqi = 8'h00;
   logic rx_ack_request = 1'b0;
   logic auto_ack_receive_state = 1'b0;
   logic tx_payload_active = 1'b0;
   logic ed_start = 1'b0;
   logic [7:0] ed_level = 8'h00;
   logic [2:0] modem_rate;
   logic chip_scramble, cca_energy_only, ed_busy, ed_done, frame_ready, frame_dropped;
   logic ack_tx_start;
   logic [7:0] ed_value;
   logic [6:0] ack_psdu_length;
   logic [7:0] fexp [0:7];
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0, drop_n = 0, ack_at = 0, fe_at = 0, busy_n = 0, d0, done_n = 0, e0;

   always #5 clock = ~clock;

   hrpmc_spi_host host (.clock, .spi_miso, .spi_sclk, .spi_mosi, .spi_sel_n);

   hrpmc_ctrl #(.ED_STD_CYC(ED_N), .ACK_LONG_CYC(ACK_N)) dut (
      .clock, .resetn, .en, .spi_sclk, .spi_mosi, .spi_sel_n, .spi_miso, .rx_sync_found,
      .rx_rssi, .rx_phr_valid, .rx_phr, .rx_data_valid, .rx_data, .rx_frame_end, .rx_crc_ok,
      .rx_lqi, .rx_ack_request, .auto_ack_receive_state, .tx_payload_active, .ed_start,
      .ed_level, .modem_rate, .chip_scramble, .cca_energy_only, .ed_busy, .ed_done, .ed_value,
      .frame_ready, .frame_dropped, .ack_tx_start, .ack_psdu_length);

   // Event monitor: pulses are counted or time-stamped here so no one-cycle output is missed.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (frame_dropped === 1'b1) drop_n <= drop_n + 1;
      if (ack_tx_start === 1'b1) ack_at <= cyc;
      if (rx_frame_end === 1'b1) fe_at <= cyc;
      if (ed_busy === 1'b1) busy_n <= busy_n + 1;
      if (ed_done === 1'b1) done_n <= done_n + 1;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s: got %h expected %h", $time, s, got, exp);
      end
   endtask : chk

   task automatic chk_n(input int got, input int lo, input int hi, input string s);
      checks++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("[ERR] %0t %s: got %0d expected %0d..%0d", $time, s, got, lo, hi);
      end
   endtask : chk_n

   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask : tdone

   task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
      host.tx_buf[0] = {2'h3, a};
      host.tx_buf[1] = d;
      host.xfer(2);
   endtask : reg_wr

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string s);
      host.tx_buf[0] = {2'h2, a};
      host.tx_buf[1] = 8'h00;
      host.xfer(2);
      chk(host.rx_buf[1], exp, s);
   endtask : rd_chk

   // One ED run counted in busy cycles; a 4-cycle enable freeze must stretch the window.
   task automatic ed_run(input int n);
      d0 = busy_n;
      e0 = done_n;
      @(posedge clock);
      ed_level <= ed_level + 8'h11;
      ed_start <= 1'b1;
      @(posedge clock);
      ed_start <= 1'b0;
      en <= 1'b0;
      repeat (4) @(posedge clock);
      en <= 1'b1;
      repeat (n + 20) @(posedge clock);
      @(negedge clock);
      chk_n(busy_n - d0, n + 4, n + 4, "ED window");
      chk_n(done_n - e0, 1, 1, "ED done");
      chk(ed_value, ed_level, "ED value");
   endtask : ed_run

   // Transmit payload phase; rate and scrambling show only while it lasts.
   task automatic tx_chk(input logic [7:0] rate, input logic [7:0] scr);
      @(posedge clock);
      tx_payload_active <= 1'b1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk({5'h00, modem_rate}, rate, "tx rate");
      chk({7'h00, chip_scramble}, scr, "tx scrambling");
      @(posedge clock);
      tx_payload_active <= 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk({5'h00, modem_rate}, 8'h00, "idle rate");
   endtask : tx_chk

   // Two byte frame; a rate of FF skips the payload rate checks.
   task automatic rx_frame(input logic [3:0] rssi, input logic [7:0] rate, input logic [7:0] scr);
      @(posedge clock);
      rx_rssi <= rssi;
      rx_sync_found <= 1'b1;
      @(posedge clock);
      rx_sync_found <= 1'b0;
      rx_phr_valid <= 1'b1;
      rx_phr <= 8'h02;
      @(negedge clock);
      chk({5'h00, modem_rate}, 8'h00, "header rate");
      @(posedge clock);
      rx_phr_valid <= 1'b0;
      rx_data_valid <= 1'b1;
      rx_data <= 8'h5A;
      @(posedge clock);
      rx_data <= 8'hC3;
      @(posedge clock);
      rx_data_valid <= 1'b0;
      rx_frame_end <= 1'b1;
      rx_lqi <= 8'h77;
      @(negedge clock);
      if (rate !== 8'hFF) begin
         chk({5'h00, modem_rate}, rate, "payload rate");
         chk({7'h00, chip_scramble}, scr, "rx scrambling");
      end
      @(posedge clock);
      rx_frame_end <= 1'b0;
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask : rx_frame

   task automatic ack_run(input int n);
      rx_frame(4'hF, 8'h03, 8'h01);
      repeat (n + 10) @(posedge clock);
      chk_n(ack_at - fe_at, n, n + 2, "ack delay");
   endtask : ack_run

   task automatic wrap_up();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // Main sequence.
   initial begin
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk({1'b0, ack_psdu_length}, 8'h05, "ack length");
      rd_chk(ADDR_TRANSCEIVER_CONTROL_TWO, 8'h20, "reset ctrl");
      rd_chk(ADDR_RECEIVE_SYNC_THRESHOLD, 8'h00, "reset thr");
      rd_chk(ADDR_EXTENDED_CONTROL, 8'h00, "reset ext");
      rd_chk(6'h3F, 8'h00, "unmapped");
      ed_run(ED_N);
      tdone("reset");
      // Every rate code; reserved codes must leave the last legal rate.
      for (int r = 0; r < 8; r++) begin
         reg_wr(ADDR_TRANSCEIVER_CONTROL_TWO, 8'hF8 | 8'(r));
         rd_chk(ADDR_TRANSCEIVER_CONTROL_TWO, 8'hA0 | 8'(r < 4 ? r : 3), "rate");
         @(negedge clock);
         chk({7'h00, cca_energy_only}, 8'(r != 0), "cca mode");
      end
      ed_run(3200);
      tx_chk(8'h03, 8'h01);
      reg_wr(ADDR_TRANSCEIVER_CONTROL_TWO, 8'h03);
      tx_chk(8'h03, 8'h00);
      reg_wr(ADDR_TRANSCEIVER_CONTROL_TWO, 8'h22);
      tx_chk(8'h02, 8'h00);
      d0 = drop_n;
      rx_frame(4'h1, 8'h02, 8'h00);
      reg_wr(ADDR_TRANSCEIVER_CONTROL_TWO, 8'h23);
      tdone("rates");
      rx_crc_ok <= 1'b0;
      rx_frame(4'h4, 8'h03, 8'h01);
      chk({7'h00, frame_ready}, 8'h01, "frame kept");
      host.tx_buf[0] = 8'h20;
      host.xfer(8);
      fexp = '{8'h83, 8'h02, 8'h5A, 8'hC3, 8'h77, ed_level, 8'h40, 8'h00};
      for (int i = 0; i < 8; i++) chk(host.rx_buf[i], fexp[i], "frame read");
      for (int i = 0; i < 2; i++) begin
         host.tx_buf[0] = i ? 8'h4C : 8'h0C;
         host.xfer(3);
         chk(host.rx_buf[1] | host.rx_buf[2], 8'h00, "bad prefix");
      end
      rx_frame(4'h3, 8'hFF, 8'h00);
      chk_n(drop_n - d0, 2, 2, "weak payload");
      reg_wr(ADDR_RECEIVE_SYNC_THRESHOLD, 8'hF5);
      rd_chk(ADDR_RECEIVE_SYNC_THRESHOLD, 8'h05, "thr");
      rx_frame(4'h4, 8'hFF, 8'h00);
      rx_frame(4'h5, 8'hFF, 8'h00);
      chk_n(drop_n - d0, 3, 3, "threshold");
      tdone("receive");
      reg_wr(ADDR_RECEIVE_SYNC_THRESHOLD, 8'h00);
      auto_ack_receive_state <= 1'b1;
      rx_ack_request <= 1'b1;
      ack_run(ACK_N);
      reg_wr(ADDR_EXTENDED_CONTROL, 8'hFF);
      rd_chk(ADDR_EXTENDED_CONTROL, 8'hF7, "ext reg");
      ack_run(3200);
      tdone("ack");
      wrap_up();
   end

   // Watchdog: the sequence needs about 11500 cycles.
   initial begin
      #500000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule : tb_top
